/* rtl/sfm_pkg.sv */
// Shared constants for the supply fault monitor: register map, field layout, timing.
package sfm_pkg;

  // Register port widths.
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 8;

  // Register offsets on the host port.
  localparam logic [ADDR_W-1:0] ADDR_FL_STATUS = 9'h030;
  localparam logic [ADDR_W-1:0] ADDR_FL_MASK = 9'h031;
  localparam logic [ADDR_W-1:0] ADDR_FAULT1 = 9'h1cc;
  localparam logic [ADDR_W-1:0] ADDR_FAULT2 = 9'h1cd;
  localparam logic [ADDR_W-1:0] ADDR_FAULT3 = 9'h1ce;
  localparam logic [ADDR_W-1:0] ADDR_FAULT4 = 9'h1cf;

  // Extended region holding the per-rail fault registers.
  localparam logic [ADDR_W-1:0] EXT_FIRST = 9'h180;
  localparam logic [ADDR_W-1:0] EXT_LAST = 9'h1ff;

  // Reset values.
  localparam logic [DATA_W-1:0] FL_STATUS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] FL_MASK_RESET = 8'h03;
  localparam logic [DATA_W-1:0] FAULT_RESET = 8'h00;

  // First-level field positions.
  localparam int unsigned THERMAL_BIT = 0;
  localparam int unsigned REG_FAULT_BIT = 2;

  // Implemented bits; everything else reads as zero.
  localparam logic [DATA_W-1:0] FL_MASK_WRITABLE = 8'h07;
  localparam logic [DATA_W-1:0] FAULT1_USED = 8'h1f;
  localparam logic [DATA_W-1:0] FAULT2_USED = 8'hf8;
  localparam logic [DATA_W-1:0] FAULT3_USED = 8'hf9;
  localparam logic [DATA_W-1:0] FAULT4_USED = 8'h0b;

  // Rail count and where each register's rails start in the rail vector.
  localparam int unsigned NUM_RAILS = 19;
  localparam int unsigned F1_BASE = 0;
  localparam int unsigned F2_BASE = 5;
  localparam int unsigned F3_BASE = 10;
  localparam int unsigned F4_BASE = 16;

  // Debounce time: one period of the slow clock, expressed in core cycles, rounded up.
  localparam int unsigned CORE_CLK_HZ = 25_000_000;
  localparam int unsigned SLOW_CLK_HZ = 32_768;
  localparam int unsigned DEBOUNCE_SLOW_PERIODS = 1;
  localparam int unsigned DEBOUNCE_CYCLES =
    (DEBOUNCE_SLOW_PERIODS * CORE_CLK_HZ + SLOW_CLK_HZ - 1) / SLOW_CLK_HZ;

  // Pin synchroniser depth.
  localparam int unsigned SYNC_STAGES = 3;

  // Thermal shutdown sequencer states.
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_OFF = 3'b010,
    ST_RESTART = 3'b100
  } therm_state_e;

endpackage : sfm_pkg

/* rtl/shutdown_debounce.sv */
// Level debouncer: output follows the input only after it has held steady for CYCLES clocks.
`timescale 1ns/1ps

module shutdown_debounce #(
  parameter int unsigned CYCLES = sfm_pkg::DEBOUNCE_CYCLES
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Synchronised level in, debounced level out.
  input wire logic level_in,
  output logic level_out
);

  localparam int unsigned CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLES - 1);

  if (CYCLES < 1) begin : g_bad_cycles
    $error("shutdown_debounce needs at least one cycle");
  end

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic level_q;
  logic level_d;

  // Any return to agreement restarts the count, so a short glitch never reaches the output.
  always_comb begin
    cnt_d = '0;
    level_d = level_q;
    if (level_in != level_q) begin
      if (cnt_q == CNT_LAST) begin
        level_d = level_in;
      end else begin
        cnt_d = cnt_q + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_q <= '0;
      level_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      level_q <= level_d;
    end
  end

  assign level_out = level_q;

  // Helper: length of the current run of a high input, saturating.
  logic [CNT_W-1:0] high_run_q;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      high_run_q <= '0;
    end else if (!level_in) begin
      high_run_q <= '0;
    end else if (high_run_q != CNT_W'(CYCLES)) begin
      high_run_q <= high_run_q + CNT_W'(1);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_debounce_hold_time: assert property (
    $rose(level_q) |-> ($past(high_run_q) >= CNT_LAST))
    else $error("debounced level rose before a full slow-clock period");

endmodule : shutdown_debounce

/* rtl/supply_fault_monitor.sv */
// Supply fault monitor: rail fault capture, thermal warning and shutdown, host interrupt.
`timescale 1ns/1ps

// Operation
// - A rising temperature past the warning threshold raises the thermal warning flag, which when unmasked drives the interrupt.
// - A junction temperature past the shutdown threshold powers the whole system off.
// - The shutdown input must hold for one full slow-clock period before it acts.
// - When the over-temperature clears after a shutdown the device restarts through its power-up sequence.
// - Each rail fault is the OR of the under-voltage, over-voltage, over-current and short faults that rail supports.
// - All rail faults OR into one regulator fault that, when unmasked, drives the interrupt.
// - The rail fault registers live in the extended region from 0x180 to 0x1ff.
// - The first rail register reports five buck faults in bits 4:0, reserved 7:5, resets to zero.
// - The second rail register reports faults in bits 7:3, reserved 2:0, resets to zero.
// - The third rail register reports faults in bits 0 and 7:3, reserved 2:1, resets to zero.
// - The fourth rail register reports faults in bits 0, 1 and 3, reserved 2 and 7:4, resets to zero.
// - The read-only first-level status shows the thermal flag in bit 0 and the regulator fault in bit 2, reset 0x00.
// - The first-level mask masks thermal with bit 0 and regulator fault with bit 2, reset 0x03.
module supply_fault_monitor #(
  parameter logic [sfm_pkg::NUM_RAILS-1:0] UV_SUPPORT = '1,
  parameter logic [sfm_pkg::NUM_RAILS-1:0] OV_SUPPORT = '1,
  parameter logic [sfm_pkg::NUM_RAILS-1:0] OC_SUPPORT = '1,
  parameter logic [sfm_pkg::NUM_RAILS-1:0] SC_SUPPORT = '1,
  parameter int unsigned DEBOUNCE_CYCLES = sfm_pkg::DEBOUNCE_CYCLES
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Raw fault inputs from the regulators, one bit per rail.
  input wire logic [sfm_pkg::NUM_RAILS-1:0] rail_uv_fault,
  input wire logic [sfm_pkg::NUM_RAILS-1:0] rail_ov_fault,
  input wire logic [sfm_pkg::NUM_RAILS-1:0] rail_oc_fault,
  input wire logic [sfm_pkg::NUM_RAILS-1:0] rail_sc_fault,
  // Thermal comparators.
  input wire logic warning_temp_threshold,
  input wire logic shutdown_temp_threshold,
  // Register port from the serial host interface.
  input wire logic [sfm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [sfm_pkg::DATA_W-1:0] reg_wdata,
  output logic [sfm_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // System outputs.
  output logic host_irq_pin,
  output logic system_power_off,
  output logic power_up_start
);

  localparam int unsigned NR = sfm_pkg::NUM_RAILS;
  localparam int unsigned DW = sfm_pkg::DATA_W;
  localparam int unsigned PIN_W = 4 * NR + 2;

  if (DEBOUNCE_CYCLES < 1) begin : g_bad_debounce
    $error("supply_fault_monitor needs a debounce of at least one cycle");
  end

  // Map the rail vector onto the four rail registers.
  function automatic logic [4*DW-1:0] rails_to_regs(input logic [NR-1:0] r);
    logic [DW-1:0] f1;
    logic [DW-1:0] f2;
    logic [DW-1:0] f3;
    logic [DW-1:0] f4;
    f1 = '0;
    f2 = '0;
    f3 = '0;
    f4 = '0;
    f1[4:0] = r[sfm_pkg::F1_BASE +: 5];
    f2[7:3] = r[sfm_pkg::F2_BASE +: 5];
    f3[0] = r[sfm_pkg::F3_BASE];
    f3[7:3] = r[sfm_pkg::F3_BASE + 1 +: 5];
    f4[1:0] = r[sfm_pkg::F4_BASE +: 2];
    f4[3] = r[sfm_pkg::F4_BASE + 2];
    return {f4, f3, f2, f1};
  endfunction : rails_to_regs

  // Inverse map, used to turn a register write into per-rail clear strobes.
  function automatic logic [NR-1:0] reg_to_rails(input logic [sfm_pkg::ADDR_W-1:0] a,
                                                 input logic [DW-1:0] d);
    logic [NR-1:0] r;
    r = '0;
    if (a == sfm_pkg::ADDR_FAULT1) begin
      r[sfm_pkg::F1_BASE +: 5] = d[4:0];
    end else if (a == sfm_pkg::ADDR_FAULT2) begin
      r[sfm_pkg::F2_BASE +: 5] = d[7:3];
    end else if (a == sfm_pkg::ADDR_FAULT3) begin
      r[sfm_pkg::F3_BASE] = d[0];
      r[sfm_pkg::F3_BASE + 1 +: 5] = d[7:3];
    end else if (a == sfm_pkg::ADDR_FAULT4) begin
      r[sfm_pkg::F4_BASE +: 2] = d[1:0];
      r[sfm_pkg::F4_BASE + 2] = d[3];
    end
    return r;
  endfunction : reg_to_rails

  // ---------------------------------------------------------------------------
  // Pin synchronisers. Three stages; a change is accepted once stages two and
  // three agree, which also rejects a one-cycle metastable disagreement.
  // ---------------------------------------------------------------------------
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] sync1_q;
  logic [PIN_W-1:0] sync2_q;
  logic [PIN_W-1:0] sync3_q;
  logic [PIN_W-1:0] clean_q;
  logic [PIN_W-1:0] clean_d;

  assign pins_raw = {shutdown_temp_threshold, warning_temp_threshold,
                     rail_sc_fault, rail_oc_fault, rail_ov_fault, rail_uv_fault};

  // Per-bit acceptance only looks at stages two and three.
  always_comb begin
    clean_d = (~(sync2_q ^ sync3_q) & sync3_q) | ((sync2_q ^ sync3_q) & clean_q);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      clean_q <= '0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      clean_q <= clean_d;
    end
  end

  logic [NR-1:0] uv_s;
  logic [NR-1:0] ov_s;
  logic [NR-1:0] oc_s;
  logic [NR-1:0] sc_s;
  logic warn_s;
  logic shut_s;

  assign uv_s = clean_q[0 +: NR];
  assign ov_s = clean_q[NR +: NR];
  assign oc_s = clean_q[2*NR +: NR];
  assign sc_s = clean_q[3*NR +: NR];
  assign warn_s = clean_q[4*NR];
  assign shut_s = clean_q[4*NR + 1];

  // ---------------------------------------------------------------------------
  // Per-rail fault combine. Unsupported fault kinds are removed by parameter so
  // a floating monitor on a rail without that protection cannot fake a fault.
  // ---------------------------------------------------------------------------
  logic [NR-1:0] per_rail_fault_signal;
  logic aggregate_regulator_fault;

  for (genvar i = 0; i < NR; i++) begin : g_rail
    assign per_rail_fault_signal[i] = (uv_s[i] & UV_SUPPORT[i]) | (ov_s[i] & OV_SUPPORT[i]) |
                                      (oc_s[i] & OC_SUPPORT[i]) | (sc_s[i] & SC_SUPPORT[i]);
  end

  // ---------------------------------------------------------------------------
  // Register decode. Rail registers answer only inside the extended region.
  // ---------------------------------------------------------------------------
  logic in_ext;
  logic wr_mask;
  logic [NR-1:0] wr_clear;

  assign in_ext = (reg_addr >= sfm_pkg::EXT_FIRST) && (reg_addr <= sfm_pkg::EXT_LAST);
  assign wr_mask = reg_wr && (reg_addr == sfm_pkg::ADDR_FL_MASK);
  assign wr_clear = (reg_wr && in_ext) ? reg_to_rails(reg_addr, reg_wdata) : '0;

  // ---------------------------------------------------------------------------
  // Rail fault status: sticky until written with a one. A fault still present
  // wins over the clear, so software cannot lose an active fault by clearing.
  // ---------------------------------------------------------------------------
  logic [NR-1:0] fault_hold_q;
  logic [NR-1:0] fault_hold_d;

  always_comb begin
    fault_hold_d = (fault_hold_q & ~wr_clear) | per_rail_fault_signal;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      fault_hold_q <= '0;
    end else begin
      fault_hold_q <= fault_hold_d;
    end
  end

  assign aggregate_regulator_fault = |fault_hold_q;

  // ---------------------------------------------------------------------------
  // First-level mask register.
  // ---------------------------------------------------------------------------
  logic [DW-1:0] first_level_fault_mask_q;
  logic [DW-1:0] first_level_fault_mask_d;
  logic thermal_warning_mask;
  logic regulator_fault_mask;

  always_comb begin
    first_level_fault_mask_d = first_level_fault_mask_q;
    if (wr_mask) begin
      first_level_fault_mask_d = reg_wdata & sfm_pkg::FL_MASK_WRITABLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      first_level_fault_mask_q <= sfm_pkg::FL_MASK_RESET;
    end else begin
      first_level_fault_mask_q <= first_level_fault_mask_d;
    end
  end

  assign thermal_warning_mask = first_level_fault_mask_q[sfm_pkg::THERMAL_BIT];
  assign regulator_fault_mask = first_level_fault_mask_q[sfm_pkg::REG_FAULT_BIT];

  // ---------------------------------------------------------------------------
  // First-level flags and the interrupt pin. The thermal flag is the live
  // comparator level, so it drops when the temperature falls back.
  // ---------------------------------------------------------------------------
  logic thermal_warning_flag;
  logic regulator_fault_present;
  logic first_level_fault_irq;
  logic irq_q;
  logic irq_d;

  assign thermal_warning_flag = warn_s;
  assign regulator_fault_present = aggregate_regulator_fault;
  assign first_level_fault_irq = (thermal_warning_flag & ~thermal_warning_mask) |
                                 (regulator_fault_present & ~regulator_fault_mask);

  always_comb begin
    irq_d = first_level_fault_irq;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign host_irq_pin = irq_q;

  // ---------------------------------------------------------------------------
  // Thermal shutdown sequencer.
  // ---------------------------------------------------------------------------
  logic shut_debounced;

  shutdown_debounce #(
    .CYCLES(DEBOUNCE_CYCLES)
  ) u_shutdown_debounce (
    .core_clk(core_clk),
    .srst(srst),
    .level_in(shut_s),
    .level_out(shut_debounced)
  );

  sfm_pkg::therm_state_e state_q;
  sfm_pkg::therm_state_e state_d;

  // Restart waits for the debounced clear too, so a noisy recovery cannot bounce power.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      sfm_pkg::ST_RUN: begin
        if (shut_debounced) begin
          state_d = sfm_pkg::ST_OFF;
        end
      end
      sfm_pkg::ST_OFF: begin
        if (!shut_debounced) begin
          state_d = sfm_pkg::ST_RESTART;
        end
      end
      sfm_pkg::ST_RESTART: begin
        state_d = shut_debounced ? sfm_pkg::ST_OFF : sfm_pkg::ST_RUN;
      end
      default: begin
        state_d = sfm_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= sfm_pkg::ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  assign system_power_off = (state_q == sfm_pkg::ST_OFF);
  assign power_up_start = (state_q == sfm_pkg::ST_RESTART);

  // ---------------------------------------------------------------------------
  // Read port. Data is registered one cycle after the read strobe; unmapped
  // addresses return zero.
  // ---------------------------------------------------------------------------
  logic [4*DW-1:0] fault_regs;
  logic [DW-1:0] rd_value;
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  assign fault_regs = rails_to_regs(fault_hold_q);

  // Reserved bits are forced to zero by the masks.
  always_comb begin
    rd_value = '0;
    if (reg_addr == sfm_pkg::ADDR_FL_STATUS) begin
      rd_value[sfm_pkg::THERMAL_BIT] = thermal_warning_flag;
      rd_value[sfm_pkg::REG_FAULT_BIT] = regulator_fault_present;
    end else if (reg_addr == sfm_pkg::ADDR_FL_MASK) begin
      rd_value = first_level_fault_mask_q;
    end else if (in_ext && reg_addr == sfm_pkg::ADDR_FAULT1) begin
      rd_value = fault_regs[0 +: DW] & sfm_pkg::FAULT1_USED;
    end else if (in_ext && reg_addr == sfm_pkg::ADDR_FAULT2) begin
      rd_value = fault_regs[DW +: DW] & sfm_pkg::FAULT2_USED;
    end else if (in_ext && reg_addr == sfm_pkg::ADDR_FAULT3) begin
      rd_value = fault_regs[2*DW +: DW] & sfm_pkg::FAULT3_USED;
    end else if (in_ext && reg_addr == sfm_pkg::ADDR_FAULT4) begin
      rd_value = fault_regs[3*DW +: DW] & sfm_pkg::FAULT4_USED;
    end
  end

  always_comb begin
    rvalid_d = reg_rd;
    rdata_d = reg_rd ? rd_value : rdata_q;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_q <= sfm_pkg::FL_STATUS_RESET;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;

  // ---------------------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_power_off;
    state_q == sfm_pkg::ST_OFF;
  endsequence

  sequence s_recovery;
    s_power_off ##0 !shut_debounced;
  endsequence

  a_thermal_irq_path: assert property (
    (thermal_warning_flag && !thermal_warning_mask) |=> host_irq_pin)
    else $error("unmasked thermal warning did not raise the interrupt");

  a_fault_irq_path: assert property (
    (|per_rail_fault_signal && !regulator_fault_mask) |=> ##1 host_irq_pin)
    else $error("unmasked rail fault did not raise the interrupt");

  a_irq_quiet_masked: assert property (
    (!(thermal_warning_flag && !thermal_warning_mask) &&
     !(regulator_fault_present && !regulator_fault_mask)) |=> !host_irq_pin)
    else $error("interrupt asserted with no unmasked flag");

  a_shutdown_entry: assert property (
    (state_q == sfm_pkg::ST_RUN && shut_debounced) |=> system_power_off)
    else $error("debounced over-temperature did not power off");

  a_restart_pulse: assert property (
    s_recovery |=> power_up_start ##1 (!power_up_start && !system_power_off))
    else $error("restart pulse missing or longer than one cycle");

  a_fault_sticky: assert property (
    (per_rail_fault_signal[0] && !wr_clear[0]) |=> fault_hold_q[0] [*2])
    else $error("rail fault was not held in its status bit");

  a_mask_write: assert property (
    wr_mask |=> (first_level_fault_mask_q == (($past(reg_wdata)) & sfm_pkg::FL_MASK_WRITABLE)))
    else $error("mask register did not take the written value");

  a_reserved_zero: assert property (
    (reg_rd && reg_addr == sfm_pkg::ADDR_FAULT4) |=> (reg_rvalid && reg_rdata[7:4] == 4'h0
                                                      && !reg_rdata[2]))
    else $error("reserved bits of the fourth rail register read non-zero");

  a_status_layout: assert property (
    (reg_rd && reg_addr == sfm_pkg::ADDR_FL_STATUS) |=>
      (reg_rdata[sfm_pkg::REG_FAULT_BIT] == $past(regulator_fault_present) &&
       reg_rdata[1] == 1'b0))
    else $error("first-level status read shows the wrong regulator fault bit");

endmodule : supply_fault_monitor

/* sim/sys_ctrl_model.sv */
// System controller model: register port master that services the fault interrupt.
`timescale 1ns/1ps

module sys_ctrl_model (
  // Clock.
  input wire logic core_clk,
  // Answers from the monitor.
  input wire logic [sfm_pkg::DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic host_irq_pin,
  // Register requests toward the monitor.
  output logic [sfm_pkg::ADDR_W-1:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [sfm_pkg::DATA_W-1:0] reg_wdata
);
  // Idle bus at time zero.
  initial begin
    reg_addr = 9'h000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // One read; released lines show the inverse so a stale value is never trusted.
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rvalid ? reg_rdata : 8'hxx;
  endtask : rd

  // One write; there is no answer to wait for.
  task automatic wr(input logic [8:0] a, input logic [7:0] v);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask : wr

  // First-level status first, then the rail registers to find the failing supply.
  task automatic service(output logic [7:0] st, output logic [7:0] fr [4]);
    rd(sfm_pkg::ADDR_FL_STATUS, st);
    for (int i = 0; i < 4; i++) begin
      rd(sfm_pkg::ADDR_FAULT1 + 9'(i), fr[i]);
    end
  endtask : service
endmodule : sys_ctrl_model

/* sim/tb_top.sv */
// Self-checking testbench for the supply fault monitor.
`timescale 1ns/1ps

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end

module tb_top;
  logic core_clk, srst, warn, sdn, irq, poff, pstart, rvalid, wr, rd;
  logic [18:0] flt [4];
  logic [8:0] addr;
  logic [7:0] wdata, rdata, d, st;
  logic [7:0] fr [4];
  int mismatches = 0, n_tests = 0, r, k, i;
  // Short debounce so the shutdown path fits a quick run.
  localparam int DEB = 4;

  supply_fault_monitor #(.DEBOUNCE_CYCLES(DEB)) supply_fault_monitor_inst (
    .core_clk(core_clk), .srst(srst), .rail_uv_fault(flt[0]), .rail_ov_fault(flt[1]),
    .rail_oc_fault(flt[2]), .rail_sc_fault(flt[3]), .warning_temp_threshold(warn),
    .shutdown_temp_threshold(sdn), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid), .host_irq_pin(irq),
    .system_power_off(poff), .power_up_start(pstart));

  sys_ctrl_model sys_ctrl_model_inst (
    .core_clk(core_clk), .reg_rdata(rdata), .reg_rvalid(rvalid), .host_irq_pin(irq),
    .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata));

  // Register that holds a given rail's status bit.
  function automatic logic [8:0] rail_addr(input int r);
    return r < 5 ? sfm_pkg::ADDR_FAULT1 : r < 10 ? sfm_pkg::ADDR_FAULT2 :
      r < 16 ? sfm_pkg::ADDR_FAULT3 : sfm_pkg::ADDR_FAULT4;
  endfunction : rail_addr

  // Bit position of a rail inside its register.
  function automatic logic [7:0] rail_bit(input int r);
    if (r < 5) return 8'h01 << r;
    if (r < 10) return 8'h08 << (r - 5);
    if (r == 10) return 8'h01;
    if (r < 16) return 8'h08 << (r - 11);
    return r == 18 ? 8'h08 : 8'h01 << (r - 16);
  endfunction : rail_bit

  // Step n edges and land just after the last one.
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  // Verdict and end of run.
  task automatic summarize();
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  // Free-running core clock.
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #1ms;
    mismatches++;
    summarize();
  end

  // Main sequence.
  initial begin
    srst = 1'b1;
    warn = 1'b0;
    sdn = 1'b0;
    for (i = 0; i < 4; i++) flt[i] = 19'h0_0000;
    void'($urandom(32'hcd7d));
    cyc(6);
    srst = 1'b0;
    sys_ctrl_model_inst.rd(sfm_pkg::ADDR_FL_STATUS, d); `CHK(d, 8'h00)
    sys_ctrl_model_inst.rd(sfm_pkg::ADDR_FL_MASK, d); `CHK(d, 8'h03)
    for (i = 0; i < 4; i++) begin
      sys_ctrl_model_inst.rd(sfm_pkg::ADDR_FAULT1 + 9'(i), d); `CHK(d, 8'h00)
    end
    sys_ctrl_model_inst.rd(9'h100, d); `CHK(d, 8'h00)
    `CHK(irq, 1'b0)
    // Status is read-only and reserved mask bits stay zero.
    sys_ctrl_model_inst.wr(sfm_pkg::ADDR_FL_STATUS, 8'hff);
    sys_ctrl_model_inst.wr(sfm_pkg::ADDR_FL_MASK, 8'hff);
    sys_ctrl_model_inst.rd(sfm_pkg::ADDR_FL_STATUS, d); `CHK(d, 8'h00)
    sys_ctrl_model_inst.rd(sfm_pkg::ADDR_FL_MASK, d); `CHK(d, 8'h07)
    // A masked regulator fault shows in status but keeps the pin low.
    flt[0][0] = 1'b1;
    cyc(7);
    `CHK(irq, 1'b0)
    sys_ctrl_model_inst.rd(sfm_pkg::ADDR_FL_STATUS, d); `CHK(d, 8'h04)
    flt[0][0] = 1'b0;
    cyc(6);
    sys_ctrl_model_inst.wr(sfm_pkg::ADDR_FAULT1, 8'hff);
    sys_ctrl_model_inst.wr(sfm_pkg::ADDR_FL_MASK, 8'h03);
    // Random rail and fault kind, with the edge rails forced first.
    for (i = 0; i < 12; i++) begin
      r = i == 0 ? 18 : i == 1 ? 10 : i == 2 ? 9 : $urandom_range(18);
      k = i == 0 ? 3 : $urandom_range(3);
      flt[k][r] = 1'b1;
      cyc(7);
      `CHK(irq, 1'b1)
      sys_ctrl_model_inst.service(st, fr);
      `CHK(st, 8'h04)
      `CHK(fr[rail_addr(r) - sfm_pkg::ADDR_FAULT1], rail_bit(r))
      flt[k][r] = 1'b0;
      cyc(6);
      sys_ctrl_model_inst.wr(rail_addr(r), rail_bit(r));
      cyc(3);
      `CHK(irq, 1'b0)
      sys_ctrl_model_inst.rd(rail_addr(r), d); `CHK(d, 8'h00)
    end
    // A clear that meets a live fault loses, so the bit and the pin stay up.
    flt[1][5] = 1'b1;
    cyc(7);
    sys_ctrl_model_inst.wr(rail_addr(5), rail_bit(5));
    sys_ctrl_model_inst.rd(rail_addr(5), d); `CHK(d, rail_bit(5))
    `CHK(irq, 1'b1)
    flt[1][5] = 1'b0;
    cyc(6);
    sys_ctrl_model_inst.wr(rail_addr(5), rail_bit(5));
    sys_ctrl_model_inst.rd(rail_addr(5), d); `CHK(d, 8'h00)
    // Thermal warning, unmasked then masked again.
    sys_ctrl_model_inst.wr(sfm_pkg::ADDR_FL_MASK, 8'h02);
    warn = 1'b1;
    cyc(7);
    `CHK(irq, 1'b1)
    sys_ctrl_model_inst.rd(sfm_pkg::ADDR_FL_STATUS, d); `CHK(d, 8'h01)
    sys_ctrl_model_inst.wr(sfm_pkg::ADDR_FL_MASK, 8'h03);
    cyc(2);
    `CHK(irq, 1'b0)
    warn = 1'b0;
    cyc(6);
    sys_ctrl_model_inst.rd(sfm_pkg::ADDR_FL_STATUS, d); `CHK(d, 8'h00)
    // A pulse shorter than the debounce is ignored.
    sdn = 1'b1;
    cyc(2);
    sdn = 1'b0;
    cyc(12);
    `CHK(poff, 1'b0)
    // Held over-temperature powers off, recovery restarts.
    sdn = 1'b1;
    for (i = 0; i < 30 && poff !== 1'b1; i++) cyc(1);
    `CHK(poff, 1'b1)
    `CHK(i, 4 + DEB + 1)
    sdn = 1'b0;
    for (i = 0; i < 30 && pstart !== 1'b1; i++) cyc(1);
    `CHK(pstart, 1'b1)
    `CHK(poff, 1'b0)
    cyc(1);
    `CHK(pstart, 1'b0)
    // A reset in mid-run brings the mask back to its reset value.
    sys_ctrl_model_inst.wr(sfm_pkg::ADDR_FL_MASK, 8'h04);
    srst = 1'b1;
    cyc(2);
    srst = 1'b0;
    sys_ctrl_model_inst.rd(sfm_pkg::ADDR_FL_MASK, d); `CHK(d, 8'h03)
    `CHK(irq, 1'b0)
    summarize();
  end
endmodule : tb_top
